// file: rtl/cfab_pkg.sv
// package: register map, field layout and timing constants of the filter/bit-timing block
package cfab_pkg;

    // ------------------------------------------------------------
    // register indices (8-bit registers, index = address)
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_DFLEN   = 5'h00;
    localparam logic [4:0] ADDR_FEN_LO  = 5'h01;
    localparam logic [4:0] ADDR_FEN_HI  = 5'h02;
    localparam logic [4:0] ADDR_LINK0   = 5'h03;
    localparam logic [4:0] ADDR_LINK7   = 5'h0A;
    localparam logic [4:0] ADDR_FILTER_MASK_CHOICE_0   = 5'h0B;
    localparam logic [4:0] ADDR_FILTER_MASK_CHOICE_3   = 5'h0E;
    localparam logic [4:0] ADDR_BT_PRE  = 5'h0F;
    localparam logic [4:0] ADDR_BT_SEG  = 5'h10;
    localparam logic [4:0] ADDR_BT_PH2  = 5'h11;
    localparam logic [4:0] ADDR_CTRL    = 5'h12;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_FEN_LO  = 8'h3F;
    localparam logic [7:0]  RST_FEN_HI  = 8'h10;
    localparam logic [63:0] RST_LINK    = 64'h0000_0000_0011_1100;
    localparam logic [31:0] RST_MSEL    = 32'h0000_0550;
    localparam logic [7:0]  RST_ZERO    = 8'h00;

    // ------------------------------------------------------------
    // field layout and codes
    // ------------------------------------------------------------
    localparam logic [7:0] DFLEN_MASK   = 8'h1F;
    localparam logic [7:0] PH2_MASK     = 8'hC7;
    localparam logic [4:0] DFLEN_MAX    = 5'h12;
    localparam logic [3:0] DLC_ZERO     = 4'h0;
    localparam logic [3:0] DLC_ONE      = 4'h1;
    localparam logic [3:0] DLC_TWO      = 4'h2;
    localparam logic [3:0] LINK_RSVD    = 4'h8;
    localparam logic [3:0] IPT_TQ       = 4'h2;
    localparam logic [1:0] TRIPLE_SPAN  = 2'h3;

    typedef enum logic [1:0] {
        CFAB_MASK0  = 2'b00,
        CFAB_MASK1  = 2'b01,
        CFAB_MASKF  = 2'b10,
        CFAB_NOMASK = 2'b11
    } cfab_msel_t;

    typedef enum logic [1:0] {
        CFAB_MODE_LEGACY = 2'b00,
        CFAB_MODE_ENH    = 2'b01,
        CFAB_MODE_FIFO   = 2'b10
    } cfab_mode_t;

    // bit-time segment lengths, all in time quanta
    typedef struct packed {
        logic [2:0] sjw_tq;
        logic [3:0] prop_tq;
        logic [3:0] ph1_tq;
        logic [3:0] ph2_tq;
    } cfab_timing_t;

endpackage

// file: rtl/cfab_core.sv
// module: acceptance setup and nominal bit-timing generator
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - in legacy mode the filter bit count reads and acts as zero.
// - extended modes: count 0 to 18 bits for data-byte filtering, per frame length.
// - zero-length frame compares no data bits.
// - one-byte frame compares low three count bits, at most 8.
// - two-byte frame compares low four count bits, at most 16.
// - three-byte frame uses whole count, at most 18.
// - acceptance setup registers exist only in modes 1 and 2.
// - one enable bit per filter, one enables it.
// - four-bit buffer pointer per filter; codes 8 to 15 reserved.
// - two-bit mask choice: mask 0, mask 1, filter 15, or none.
// - bit-timing registers writable only in configuration mode.
// - jump width is field plus one quanta.
// - quantum is two times (prescaler plus one) oscillator clocks.
// - phase 2 free when select set, else max of phase 1 and processing time.
// - triple sampling takes three samples, two before the sample point and one at it.
// - phase 1 is field plus one quanta.
// - propagation is field plus one quanta.
// - phase 2 field plus one, ignored while select is clear.
// - wake disable bit blocks bus-activity wake-up.
// - wake filter bit passes the line through the filter before detection.
// - unimplemented bits read as zero.
module cfab_core
    import cfab_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic [1:0]  op_mode,
    input  wire logic        config_mode,
    input  wire logic [3:0]  frame_length_code,
    input  wire logic [3:0]  filter_sel,
    input  wire logic        can_rx,
    output logic      [4:0]  data_bits_compared,
    output logic             filter_on,
    output logic      [3:0]  filter_target_buffer,
    output logic             target_reserved,
    output logic      [1:0]  filter_mask_choice,
    output cfab_timing_t     timing,
    output logic             tq_tick,
    output logic             sample_tick,
    output logic             sample_pulse,
    output logic             rx_sampled,
    output logic             bus_wake
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] plus_one(input logic [2:0] f);
        plus_one = {1'b0, f} + 4'h1;
    endfunction

    function automatic logic [4:0] min5(input logic [4:0] a, input logic [4:0] b);
        min5 = (a < b) ? a : b;
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [4:0]  dflen_q;
    logic [15:0] fen_q;
    logic [63:0] link_q;
    logic [31:0] msel_q;
    logic [7:0]  bt_pre_q;
    logic [7:0]  bt_seg_q;
    logic [7:0]  bt_ph2_q;
    logic        ext_mode;
    logic [2:0]  link_idx;
    logic [1:0]  msel_idx;

    assign ext_mode = (op_mode == CFAB_MODE_ENH) || (op_mode == CFAB_MODE_FIFO);
    assign link_idx = 3'(reg_addr - ADDR_LINK0);
    assign msel_idx = 2'(reg_addr - ADDR_FILTER_MASK_CHOICE_0);

    // acceptance setup; writes land only in extended modes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dflen_q <= RST_ZERO[4:0];
            fen_q   <= {RST_FEN_HI, RST_FEN_LO};
            link_q  <= RST_LINK;
            msel_q  <= RST_MSEL;
        end else if (reg_wr && ext_mode) begin
            if (reg_addr == ADDR_DFLEN) begin
                dflen_q <= reg_wdata[4:0];
            end
            if (reg_addr == ADDR_FEN_LO) begin
                fen_q[7:0] <= reg_wdata;
            end
            if (reg_addr == ADDR_FEN_HI) begin
                fen_q[15:8] <= reg_wdata;
            end
            if (reg_addr >= ADDR_LINK0 && reg_addr <= ADDR_LINK7) begin
                link_q[link_idx*8 +: 8] <= reg_wdata;
            end
            if (reg_addr >= ADDR_FILTER_MASK_CHOICE_0 && reg_addr <= ADDR_FILTER_MASK_CHOICE_3) begin
                msel_q[msel_idx*8 +: 8] <= reg_wdata;
            end
        end
    end

    // bit-timing registers are locked outside configuration mode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bt_pre_q <= RST_ZERO;
            bt_seg_q <= RST_ZERO;
            bt_ph2_q <= RST_ZERO;
        end else if (reg_wr && config_mode) begin
            if (reg_addr == ADDR_BT_PRE) begin
                bt_pre_q <= reg_wdata;
            end
            if (reg_addr == ADDR_BT_SEG) begin
                bt_seg_q <= reg_wdata;
            end
            if (reg_addr == ADDR_BT_PH2) begin
                bt_ph2_q <= reg_wdata & PH2_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // read port, data one cycle after the strobe
    // ------------------------------------------------------------
    logic [7:0] rd_d;
    always_comb begin
        rd_d = RST_ZERO;
        if (reg_addr == ADDR_BT_PRE) begin
            rd_d = bt_pre_q;
        end else if (reg_addr == ADDR_BT_SEG) begin
            rd_d = bt_seg_q;
        end else if (reg_addr == ADDR_BT_PH2) begin
            rd_d = bt_ph2_q;
        end else if (reg_addr == ADDR_CTRL) begin
            rd_d = {6'h00, op_mode};
        end else if (ext_mode) begin
            if (reg_addr == ADDR_DFLEN) begin
                rd_d = {3'h0, dflen_q};
            end else if (reg_addr == ADDR_FEN_LO) begin
                rd_d = fen_q[7:0];
            end else if (reg_addr == ADDR_FEN_HI) begin
                rd_d = fen_q[15:8];
            end else if (reg_addr >= ADDR_LINK0 && reg_addr <= ADDR_LINK7) begin
                rd_d = link_q[link_idx*8 +: 8];
            end else if (reg_addr >= ADDR_FILTER_MASK_CHOICE_0 && reg_addr <= ADDR_FILTER_MASK_CHOICE_3) begin
                rd_d = msel_q[msel_idx*8 +: 8];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= RST_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= rd_d;
        end else begin
            reg_rdata <= RST_ZERO;
        end
    end

    // ------------------------------------------------------------
    // data-byte filter length per received frame
    // ------------------------------------------------------------
    logic [4:0] eff_len;
    logic [4:0] cmp_d;
    assign eff_len = ext_mode ? dflen_q : RST_ZERO[4:0];

    always_comb begin
        // one- and two-byte frames keep only the low count bits; longer frames clamp the count to 18
        case (frame_length_code)
            DLC_ZERO: cmp_d = 5'h00;
            DLC_ONE:  cmp_d = min5({2'b00, eff_len[2:0]}, 5'h08);
            DLC_TWO:  cmp_d = min5({1'b0, eff_len[3:0]}, 5'h10);
            default:  cmp_d = min5(eff_len, DFLEN_MAX);
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            data_bits_compared <= 5'h00;
        end else begin
            data_bits_compared <= cmp_d;
        end
    end

    // per-filter lookups for the matcher
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            filter_on            <= 1'b0;
            filter_target_buffer <= 4'h0;
            target_reserved      <= 1'b0;
            filter_mask_choice   <= 2'b00;
        end else begin
            filter_on            <= ext_mode && fen_q[filter_sel];
            filter_target_buffer <= link_q[filter_sel*4 +: 4];
            target_reserved      <= link_q[filter_sel*4 + 3] == LINK_RSVD[3];
            filter_mask_choice   <= msel_q[filter_sel*2 +: 2];
        end
    end

    // ------------------------------------------------------------
    // segment lengths
    // ------------------------------------------------------------
    logic [3:0] ph1_len;
    logic [3:0] ph2_len;
    assign ph1_len = plus_one(bt_seg_q[5:3]);
    assign ph2_len = bt_seg_q[7] ? plus_one(bt_ph2_q[2:0])
                   : ((ph1_len > IPT_TQ) ? ph1_len : IPT_TQ);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timing <= '0;
        end else begin
            timing.sjw_tq  <= 3'({1'b0, bt_pre_q[7:6]} + 3'h1);
            timing.prop_tq <= plus_one(bt_seg_q[2:0]);
            timing.ph1_tq  <= ph1_len;
            timing.ph2_tq  <= ph2_len;
        end
    end

    // ------------------------------------------------------------
    // quantum divider: 2*(prescaler+1) clocks per quantum
    // ------------------------------------------------------------
    logic [6:0] pre_cnt_q;
    logic [6:0] pre_top;
    assign pre_top = 7'({1'b0, bt_pre_q[5:0]} * 7'h2 + 7'h1);
    always_ff @(posedge sys_clk) begin
        if (rst || config_mode) begin
            pre_cnt_q <= 7'h00;
            tq_tick   <= 1'b0;
        end else if (pre_cnt_q >= pre_top) begin
            pre_cnt_q <= 7'h00;
            tq_tick   <= 1'b1;
        end else begin
            pre_cnt_q <= pre_cnt_q + 7'h1;
            tq_tick   <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // bit-time sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CFAB_SYNC  = 2'b00,
        CFAB_PROP  = 2'b01,
        CFAB_PH1   = 2'b10,
        CFAB_PH2   = 2'b11
    } cfab_seg_t;

    cfab_seg_t  seg_q;
    logic [3:0] seg_cnt_q;
    logic [2:0] samp_q;
    logic [3:0] prop_len;
    assign prop_len = plus_one(bt_seg_q[2:0]);

    always_ff @(posedge sys_clk) begin
        if (rst || config_mode) begin
            seg_q     <= CFAB_SYNC;
            seg_cnt_q <= 4'h1;
        end else if (tq_tick) begin
            case (seg_q)
                CFAB_SYNC: begin
                    seg_q     <= CFAB_PROP;
                    seg_cnt_q <= 4'h1;
                end
                CFAB_PROP: begin
                    if (seg_cnt_q >= prop_len) begin
                        seg_q     <= CFAB_PH1;
                        seg_cnt_q <= 4'h1;
                    end else begin
                        seg_cnt_q <= seg_cnt_q + 4'h1;
                    end
                end
                CFAB_PH1: begin
                    if (seg_cnt_q >= ph1_len) begin
                        seg_q     <= CFAB_PH2;
                        seg_cnt_q <= 4'h1;
                    end else begin
                        seg_cnt_q <= seg_cnt_q + 4'h1;
                    end
                end
                CFAB_PH2: begin
                    if (seg_cnt_q >= ph2_len) begin
                        seg_q     <= CFAB_SYNC;
                        seg_cnt_q <= 4'h1;
                    end else begin
                        seg_cnt_q <= seg_cnt_q + 4'h1;
                    end
                end
                default: begin
                    seg_q     <= CFAB_SYNC;
                    seg_cnt_q <= 4'h1;
                end
            endcase
        end
    end

    // last quantum of phase 1 closes on the sample point
    assign sample_tick = tq_tick && (seg_q == CFAB_PH1) && (seg_cnt_q >= ph1_len);

    // three samples taken on the quanta leading to the sample point
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            samp_q       <= 3'h7;
            rx_sampled   <= 1'b1;
            sample_pulse <= 1'b0;
        end else begin
            sample_pulse <= sample_tick;
            if (tq_tick) begin
                samp_q <= {samp_q[1:0], can_rx};
            end
            if (sample_tick) begin
                if (bt_seg_q[6]) begin
                    // majority of the last three quanta, this one included
                    rx_sampled <= (samp_q[1] & samp_q[0]) | (samp_q[1] & can_rx)
                                | (samp_q[0] & can_rx);
                end else begin
                    rx_sampled <= can_rx;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // bus-activity wake-up
    // ------------------------------------------------------------
    logic [TRIPLE_SPAN-2'h2:0] wfilt_q;
    logic                      line_low;
    // filter trades a two-clock delay for rejection of glitches up to two clocks long
    assign line_low = bt_ph2_q[6] ? (~can_rx & ~wfilt_q[0] & ~wfilt_q[1])
                                  : ~can_rx;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wfilt_q  <= '1;
            bus_wake <= 1'b0;
        end else begin
            wfilt_q  <= {wfilt_q[0], can_rx};
            bus_wake <= line_low && !bt_ph2_q[7];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_legacy_len_zero: assert property (@(posedge sys_clk) disable iff (rst)
        !ext_mode |=> data_bits_compared == 5'h00)
        else $error("legacy mode compared data bits");
    a_len_bound: assert property (@(posedge sys_clk) disable iff (rst)
        data_bits_compared <= DFLEN_MAX)
        else $error("compare count above maximum");
    a_dlc_zero: assert property (@(posedge sys_clk) disable iff (rst)
        frame_length_code == DLC_ZERO |=> data_bits_compared == 5'h00)
        else $error("zero-length frame compared bits");
    a_dlc_one: assert property (@(posedge sys_clk) disable iff (rst)
        frame_length_code == DLC_ONE |=> data_bits_compared <= 5'h08)
        else $error("one-byte compare exceeds 8");
    a_bt_locked: assert property (@(posedge sys_clk) disable iff (rst)
        !config_mode |=> $stable(bt_pre_q) && $stable(bt_seg_q))
        else $error("bit timing changed outside config mode");
    a_legacy_nowrite: assert property (@(posedge sys_clk) disable iff (rst)
        !ext_mode |=> $stable(fen_q) && $stable(link_q))
        else $error("acceptance setup written in legacy mode");
    a_ph2_floor: assert property (@(posedge sys_clk) disable iff (rst)
        !bt_seg_q[7] |-> ph2_len >= ph1_len && ph2_len >= IPT_TQ)
        else $error("phase 2 below phase 1 or processing time");
    a_wake_block: assert property (@(posedge sys_clk) disable iff (rst)
        bt_ph2_q[7] && $past(bt_ph2_q[7]) |-> !bus_wake)
        else $error("wake while disabled");
    a_sample_in_ph1: assert property (@(posedge sys_clk) disable iff (rst)
        sample_tick |=> seg_q == CFAB_PH2 || config_mode)
        else $error("sample point not at phase 1 end");

endmodule
`default_nettype wire

// file: sim/cfab_bus_node.sv
// bus node model: holds the receive line dominant for a set number of clocks
`timescale 1ns/1ps
`default_nettype none
module cfab_bus_node (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire logic [7:0] dom_len,
    output logic            can_rx
);
    // ------------------------------------------------------------
    // dominant window
    // ------------------------------------------------------------
    logic [7:0] left_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            left_q <= 8'h00;
        end else if (go) begin
            left_q <= dom_len;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end

    // idle line rests recessive through the transceiver bias, so no stale level
    assign can_rx = (left_q == 8'h00);
endmodule
`default_nettype wire

// file: sim/tb_can_filter_assoc_bit_timing.sv
// testbench: register map, filter setup and bit timing of the configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_can_filter_assoc_bit_timing
    import cfab_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic             sys_clk, rst, reg_wr, reg_rd, config_mode, can_rx, go;
    logic       [4:0] reg_addr, data_bits_compared;
    logic       [7:0] reg_wdata, reg_rdata, dom_len;
    logic       [1:0] op_mode, filter_mask_choice;
    logic       [3:0] frame_length_code, filter_sel, filter_target_buffer;
    logic             filter_on, target_reserved, tq_tick, sample_tick, sample_pulse;
    logic             rx_sampled, bus_wake;
    cfab_timing_t     timing;
    int               err_count, check_count;
    logic       [4:0] cnts [3];

    cfab_core cfab_core_inst (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_mode(op_mode),
        .config_mode(config_mode), .frame_length_code(frame_length_code),
        .filter_sel(filter_sel), .can_rx(can_rx), .data_bits_compared(data_bits_compared),
        .filter_on(filter_on), .filter_target_buffer(filter_target_buffer),
        .target_reserved(target_reserved), .filter_mask_choice(filter_mask_choice),
        .timing(timing), .tq_tick(tq_tick), .sample_tick(sample_tick),
        .sample_pulse(sample_pulse), .rx_sampled(rx_sampled), .bus_wake(bus_wake)
    );

    cfab_bus_node cfab_bus_node_inst (
        .sys_clk(sys_clk), .rst(rst), .go(go), .dom_len(dom_len), .can_rx(can_rx)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task results;
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task rd(input logic [4:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        chk($sformatf("reg %h", a), exp, reg_rdata);
    endtask

    task setm(input logic [1:0] m, input logic c);
        @(posedge sys_clk);
        op_mode     <= m;
        config_mode <= c;
    endtask

    task sel(input logic [3:0] f, input logic [3:0] d);
        @(posedge sys_clk);
        filter_sel        <= f;
        frame_length_code <= d;
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    task tchk(input logic [3:0] s, input logic [3:0] p, input logic [3:0] a,
              input logic [3:0] b);
        repeat (2) @(negedge sys_clk);
        chk("sjw_tq", 8'(s), 8'(timing.sjw_tq));
        chk("prop_tq", 8'(p), 8'(timing.prop_tq));
        chk("ph1_tq", 8'(a), 8'(timing.ph1_tq));
        chk("ph2_tq", 8'(b), 8'(timing.ph2_tq));
    endtask

    task kick(input logic [7:0] n);
        @(posedge sys_clk);
        go      <= 1'b1;
        dom_len <= n;
        @(posedge sys_clk);
        go      <= 1'b0;
    endtask

    task wake(input logic [7:0] n, input logic e);
        logic seen;
        kick(n);
        seen = 1'b0;
        repeat (12) begin
            @(negedge sys_clk);
            seen = seen | bus_wake;
        end
        chk("bus_wake", {7'h00, e}, {7'h00, seen});
    endtask

    function automatic logic pick(input bit s);
        return s ? sample_pulse : tq_tick;
    endfunction

    // first pass finds a pulse, second counts clocks to the next one
    task gap(input bit s, input logic [7:0] exp);
        int   n;
        logic tp;
        repeat (2) begin
            n = 0;
            do begin
                tp = sample_tick;
                @(negedge sys_clk);
                n++;
            end while (pick(s) !== 1'b1 && n < 200);
        end
        if (n >= 200) begin
            err_count++;
            results();
        end
        chk(s ? "bit period" : "quantum period", exp, n[7:0]);
        // sample point shows combinationally one clock ahead of its registered pulse
        if (s) chk("sample_tick", 8'h01, {7'h00, tp});
    endtask

    function automatic logic [7:0] bits_exp(input logic [4:0] c, input logic [3:0] d);
        if (d == 4'h0) return 8'h00;
        if (d == 4'h1) return {5'h00, c[2:0]};
        if (d == 4'h2) return {4'h0, c[3:0]};
        return (c > 5'h12) ? 8'h12 : {3'h0, c};
    endfunction

    function automatic logic [7:0] rst_exp(input logic [4:0] a);
        case (a)
            ADDR_FEN_LO: return 8'h3F;
            ADDR_FEN_HI: return 8'h10;
            5'h04, 5'h05: return 8'h11;
            ADDR_FILTER_MASK_CHOICE_0: return 8'h50;
            5'h0C: return 8'h05;
            default: return 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, go, config_mode} = 4'h0;
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
        dom_len = 8'h00;
        op_mode = 2'h1;
        frame_length_code = 4'h0;
        filter_sel = 4'h0;
        err_count = 0;
        check_count = 0;
        cnts = '{5'h12, 5'h0F, 5'h0B};
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        for (int a = 0; a <= 17; a++) rd(5'(a), rst_exp(5'(a)));
        rd(5'h13, 8'h00);
        wr(ADDR_DFLEN, 8'hFF);
        rd(ADDR_DFLEN, 8'h1F);
        setm(2'h0, 1'b0);
        wr(ADDR_FEN_LO, 8'h00);
        rd(ADDR_FEN_LO, 8'h00);
        rd(ADDR_DFLEN, 8'h00);
        sel(4'h0, 4'h3);
        chk("data_bits_compared", 8'h00, {3'h0, data_bits_compared});
        setm(2'h2, 1'b0);
        rd(ADDR_CTRL, 8'h02);
        rd(ADDR_FEN_LO, 8'h3F);
        wr(ADDR_FEN_LO, 8'hAA);
        wr(ADDR_FEN_HI, 8'hAA);
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_LINK0 + 5'(k), {4'(2 * k + 1), 4'(2 * k)});
        end
        for (int k = 0; k < 4; k++) wr(ADDR_FILTER_MASK_CHOICE_0 + 5'(k), 8'hE4);
        for (int f = 0; f < 16; f++) begin
            sel(4'(f), 4'h0);
            chk("filter_on", 8'(f % 2), {7'h00, filter_on});
            chk("target_buffer", 8'(f), {4'h0, filter_target_buffer});
            chk("target_reserved", 8'(f >= 8), {7'h00, target_reserved});
            chk("mask_choice", 8'(f % 4), {6'h00, filter_mask_choice});
        end
        setm(2'h1, 1'b0);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_DFLEN, {3'h0, cnts[i]});
            for (int d = 0; d < 5; d++) begin
                sel(4'h0, 4'(d));
                chk("data_bits_compared", bits_exp(cnts[i], 4'(d)),
                    {3'h0, data_bits_compared});
            end
        end
        setm(2'h1, 1'b1);
        wr(ADDR_BT_PRE, 8'h81);
        wr(ADDR_BT_SEG, 8'h51);
        wr(ADDR_BT_PH2, 8'hFF);
        rd(ADDR_BT_PH2, 8'hC7);
        wr(ADDR_BT_PH2, 8'h05);
        tchk(4'h3, 4'h2, 4'h3, 4'h3);
        setm(2'h1, 1'b0);
        wr(ADDR_BT_PRE, 8'h3F);
        rd(ADDR_BT_PRE, 8'h81);
        gap(1'b0, 8'd4);
        gap(1'b1, 8'd36);
        kick(8'd100);
        repeat (75) @(negedge sys_clk);
        chk("rx_sampled", 8'h00, {7'h00, rx_sampled});
        repeat (100) @(negedge sys_clk);
        chk("rx_sampled", 8'h01, {7'h00, rx_sampled});
        setm(2'h1, 1'b1);
        wr(ADDR_BT_SEG, 8'h80);
        tchk(4'h3, 4'h1, 4'h1, 4'h6);
        wr(ADDR_BT_SEG, 8'h00);
        tchk(4'h3, 4'h1, 4'h1, IPT_TQ);
        wr(ADDR_BT_PH2, 8'h80);
        setm(2'h1, 1'b0);
        wake(8'd6, 1'b0);
        setm(2'h1, 1'b1);
        wr(ADDR_BT_PH2, 8'h00);
        setm(2'h1, 1'b0);
        wake(8'd6, 1'b1);
        wake(8'd1, 1'b1);
        setm(2'h1, 1'b1);
        wr(ADDR_BT_PH2, 8'h40);
        setm(2'h1, 1'b0);
        wake(8'd1, 1'b0);
        wake(8'd6, 1'b1);
        results();
    end
endmodule
`default_nettype wire
